/* File: pkg/bridge_ctrl_consts.vh */
// Constants for the bridge control configuration bank
// Notes on behaviour
// [RULE1] Read-only interrupt-pin byte 15:8, reset 00h
// [RULE2] Downstream pin default overridable by sideband load
// [RULE3] Bit 16 enables secondary poisoned-packet reporting
// [RULE4] Bit 17 gates secondary error message forwarding
// [RULE5] Bit 18 clear: forward whole I/O window downstream
// [RULE6] Bit 18 set: top 768 bytes/1KB go upstream
// [RULE7] Bit 19 forwards legacy display memory and I/O
// [RULE8] Display memory window A0000h through BFFFFh
// [RULE9] Display I/O 3B0-3BBh, 3C0-3DFh, first 64KB
// [RULE10] Bit 20 selects 10-bit or 16-bit display decode
// [RULE11] Bit 22 triggers hot reset on the port
// [RULE12] Downstream port asserts its own reset output
// [RULE13] Upstream port asserts every downstream reset output
// [RULE14] Bits 21, 23-27 read zero always
// [RULE15] Reserved bits 31:28 read zero, writes ignored
`ifndef BRIDGE_CTRL_CONSTS_VH
`define BRIDGE_CTRL_CONSTS_VH
`define OFS_INT_BRIDGE     12'h03c
`define OFS_IRQ_STATUS     12'h100
`define OFS_IRQ_MASK       12'h104
`define OFS_IO_WINDOW      12'h108
`define INT_LINE_LSB       0
`define INT_PIN_LSB        8
`define BIT_POISON_EN      16
`define BIT_ERR_FWD_EN     17
`define BIT_IO_ALIAS_EN    18
`define BIT_DISPLAY_EN     19
`define BIT_DISPLAY_16B    20
`define BIT_SEC_RESET      22
`define RST_INT_PIN        8'h00
`define BC_WRITABLE_MASK   32'h005f_00ff
`define DISP_MEM_LO        32'h000a_0000
`define DISP_MEM_HI        32'h000b_ffff
`define DISP_IO_A_LO       10'h3b0
`define DISP_IO_A_HI       10'h3bb
`define DISP_IO_B_LO       10'h3c0
`define DISP_IO_B_HI       10'h3df
`define ALIAS_BLOCK_LO     10'h100
`define IO_64K_LIMIT       32'h0000_ffff
`define IRQ_POISON         0
`define IRQ_ERR_FWD        1
`define IRQ_HOT_RESET      2
`endif

/* File: verilog/bridge_control_config_bank.v */
// Interrupt-pin and bridge control configuration bank with APB access
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "bridge_ctrl_consts.vh"
module bridge_control_config_bank #(
    parameter       IS_UPSTREAM = 0,           // 1 for the upstream port
    parameter       NUM_DOWN    = 5,           // Downstream ports fed by upstream reset
    parameter [7:0] PIN_DEFAULT = 8'h01        // Downstream pin default before override
) (
    input  wire                clock,           // Core clock
    input  wire                rst_n,           // Async reset, active low
    input  wire                psel,            // APB select
    input  wire                penable,         // APB access phase
    input  wire                pwrite,          // APB direction
    input  wire [11:0]         paddr,           // APB byte address
    input  wire [31:0]         pwdata,          // APB write data
    output reg  [31:0]         prdata,          // APB read data
    output reg                 pready,          // APB ready
    output reg                 pslverr,         // APB error
    input  wire                pin_load_valid,  // Sideband/EEPROM load strobe
    input  wire [7:0]          pin_load_value,  // Value to load into pin byte
    input  wire                poison_seen,     // Poisoned packet on secondary
    input  wire                sec_err_msg,     // Error message from secondary
    input  wire                io_req,          // I/O request to classify
    input  wire [31:0]         io_addr,         // I/O address
    input  wire                mem_req,         // Memory request to classify
    input  wire [31:0]         mem_addr,        // Memory address
    output reg                 poison_report,   // Poison report pulse
    output reg                 err_fwd,         // Forwarded error pulse
    output reg                 io_fwd_down,     // I/O goes downstream
    output reg                 io_fwd_up,       // I/O goes upstream
    output reg                 disp_io_fwd,     // Display I/O forwarded
    output reg                 disp_mem_fwd,    // Display memory forwarded
    output reg                 hot_reset,       // Hot reset level
    output reg  [NUM_DOWN-1:0] port_rst_n,      // Reset outputs, active low
    output reg                 irq              // Level interrupt
);
    reg  [7:0]  int_line_r;                     // Interrupt line byte
    reg  [7:0]  int_pin_r;                      // Interrupt pin byte
    reg  [6:0]  bc_r;                           // Bridge control bits 22:16
    reg  [2:0]  irq_stat_r;                     // Sticky events
    reg  [2:0]  irq_mask_r;                     // Event enables
    reg  [15:0] io_base_r;                      // I/O window base bits 31:16
    reg  [15:0] io_limit_r;                     // I/O window limit bits 31:16
    reg         pin_init_r;                     // Downstream default applied
    reg  [31:0] rd_nxt;                         // Read mux
    reg         hit_nxt;                        // Mapped address
    wire        setup_ok = psel & ~penable;     // Setup phase
    wire        wr_acc   = psel & penable & pwrite & pready;
    wire [31:0] bc_word  = {4'h0, 5'h00, bc_r[6], 1'b0, bc_r[4:0], 16'h0000};
    wire [9:0]  lo10     = io_addr[9:0];
    wire        io_in_win = (io_addr[31:16] >= io_base_r) && (io_addr[31:16] <= io_limit_r);
    wire        io_alias  = (io_addr <= `IO_64K_LIMIT) && (lo10 >= `ALIAS_BLOCK_LO);
    wire        disp_lo   = ((lo10 >= `DISP_IO_A_LO) && (lo10 <= `DISP_IO_A_HI)) ||
                            ((lo10 >= `DISP_IO_B_LO) && (lo10 <= `DISP_IO_B_HI));
    wire        disp_io_hit = disp_lo && (io_addr <= `IO_64K_LIMIT) &&
                              (bc_r[`BIT_DISPLAY_16B-16] || 1'b1) &&
                              (~bc_r[`BIT_DISPLAY_16B-16] || (io_addr[15:10] == 6'h00));
    wire [2:0]  ev = {bc_r[`BIT_SEC_RESET-16] & ~hot_reset,
                      sec_err_msg & bc_r[`BIT_ERR_FWD_EN-16],
                      poison_seen & bc_r[`BIT_POISON_EN-16]};

    // Read mux and decode
    always @* begin
        rd_nxt  = 32'h0000_0000;
        hit_nxt = 1'b1;
        case (paddr)
            `OFS_INT_BRIDGE: rd_nxt = bc_word | {16'h0000, int_pin_r, int_line_r}; // [RULE1] [RULE14] [RULE15]
            `OFS_IRQ_STATUS: rd_nxt = {29'h0, irq_stat_r};
            `OFS_IRQ_MASK:   rd_nxt = {29'h0, irq_mask_r};
            `OFS_IO_WINDOW:  rd_nxt = {io_limit_r, io_base_r};
            default:         hit_nxt = 1'b0;
        endcase
    end

    // APB answer: no wait states, error on unmapped
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (setup_ok) begin
            pready  <= 1'b1;
            pslverr <= ~hit_nxt;
            prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Register writes and pin byte loading
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            int_line_r <= 8'h00;
            int_pin_r  <= `RST_INT_PIN;
            bc_r       <= 7'h00;
            irq_mask_r <= 3'h0;
            io_base_r  <= 16'h0000;
            io_limit_r <= 16'h0000;
            pin_init_r <= 1'b0;
        end else begin
            // Downstream default, then sideband override
            if (IS_UPSTREAM == 0) begin
                if (pin_load_valid) begin
                    int_pin_r <= pin_load_value; // [RULE2]
                end else if (!pin_init_r) begin
                    int_pin_r <= PIN_DEFAULT;
                end
                pin_init_r <= 1'b1;
            end
            if (wr_acc && hit_nxt) begin
                case (paddr)
                    `OFS_INT_BRIDGE: begin
                        int_line_r <= pwdata[7:0];
                        bc_r       <= pwdata[22:16] & 7'h5f; // [RULE14] [RULE15]
                    end
                    `OFS_IRQ_MASK:  irq_mask_r <= pwdata[2:0];
                    `OFS_IO_WINDOW: begin
                        io_base_r  <= pwdata[15:0];
                        io_limit_r <= pwdata[31:16];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Sticky status, set wins over write-one-clear
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_r <= 3'h0;
            irq        <= 1'b0;
        end else begin
            if (wr_acc && (paddr == `OFS_IRQ_STATUS)) begin
                irq_stat_r <= (irq_stat_r & ~pwdata[2:0]) | ev;
            end else begin
                irq_stat_r <= irq_stat_r | ev;
            end
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // Traffic classification and reset outputs
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            poison_report <= 1'b0;
            err_fwd       <= 1'b0;
            io_fwd_down   <= 1'b0;
            io_fwd_up     <= 1'b0;
            disp_io_fwd   <= 1'b0;
            disp_mem_fwd  <= 1'b0;
            hot_reset     <= 1'b0;
            port_rst_n    <= {NUM_DOWN{1'b1}};
        end else begin
            poison_report <= poison_seen & bc_r[`BIT_POISON_EN-16]; // [RULE3]
            err_fwd       <= sec_err_msg & bc_r[`BIT_ERR_FWD_EN-16]; // [RULE4]
            // Alias bit splits the window
            io_fwd_down <= io_req & io_in_win &
                           ~(bc_r[`BIT_IO_ALIAS_EN-16] & io_alias); // [RULE5]
            io_fwd_up   <= io_req & io_in_win &
                           bc_r[`BIT_IO_ALIAS_EN-16] & io_alias; // [RULE6]
            // 10-bit decode ignores bits 15:10
            disp_io_fwd <= io_req & bc_r[`BIT_DISPLAY_EN-16] & disp_io_hit; // [RULE7] [RULE9] [RULE10]
            disp_mem_fwd <= mem_req & bc_r[`BIT_DISPLAY_EN-16] &
                            (mem_addr >= `DISP_MEM_LO) && (mem_addr <= `DISP_MEM_HI); // [RULE8]
            hot_reset <= bc_r[`BIT_SEC_RESET-16]; // [RULE11]
            if (IS_UPSTREAM != 0) begin
                port_rst_n <= {NUM_DOWN{~bc_r[`BIT_SEC_RESET-16]}}; // [RULE13]
            end else begin
                port_rst_n <= {{(NUM_DOWN-1){1'b1}}, ~bc_r[`BIT_SEC_RESET-16]}; // [RULE12]
            end
        end
    end
endmodule

/* File: tb/sec_side_model.sv */
// Model of the secondary side raising event pulses
`timescale 1ns/100ps
module sec_side_model (
    input  wire       clock,
    input  wire [1:0] kick,
    output reg        poison_seen = 1'b0,
    output reg        sec_err_msg = 1'b0
);
    // Pulses follow kick one cycle later and last as long as kick, idle low otherwise
    always @(posedge clock) begin
        poison_seen <= kick[0];
        sec_err_msg <= kick[1];
    end
endmodule

/* File: tb/bridge_bank_checker.sv */
// Port assertions for the bridge control bank
`timescale 1ns/100ps
module bridge_bank_checker (
    input wire        clock,
    input wire        rst_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire [31:0] io_addr,
    input wire [31:0] mem_addr,
    input wire        poison_seen,
    input wire        sec_err_msg,
    input wire        poison_report,
    input wire        err_fwd,
    input wire        io_fwd_down,
    input wire        io_fwd_up,
    input wire        disp_io_fwd,
    input wire        disp_mem_fwd
);
    logic [31:0] ia_r;  // Address seen one cycle back
    logic [31:0] ma_r;  // Memory address one cycle back
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Request addresses delayed to line up with registered outputs
    always @(posedge clock) begin
        ia_r <= io_addr;
        ma_r <= mem_addr;
    end
    ready_after_setup_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    ready_once_a: assert property (pready |=> !pready) else $error("ready held too long");
    fixed_zero_a: assert property (pready && !pwrite && paddr == 12'h03c |-> (prdata & 32'hffa0_0000) == 32'h0)
        else $error("fixed bits not zero");
    poison_cause_a: assert property (poison_report |-> $past(poison_seen)) else $error("report without poison");
    err_cause_a: assert property (err_fwd |-> $past(sec_err_msg)) else $error("forward without message");
    io_one_way_a: assert property (!(io_fwd_up && io_fwd_down)) else $error("both directions");
    alias_region_a: assert property (io_fwd_up |-> ia_r <= 32'h0000_ffff && ia_r[9:0] >= 10'h100)
        else $error("upstream outside alias region");
    disp_mem_a: assert property (disp_mem_fwd |-> ma_r inside {[32'h000a_0000:32'h000b_ffff]})
        else $error("display memory out of range");
    disp_io_a: assert property (disp_io_fwd |-> ia_r <= 32'h0000_ffff &&
        ia_r[9:0] inside {[10'h3b0:10'h3bb], [10'h3c0:10'h3df]}) else $error("display io out of range");
    cover property (poison_report);
    cover property (io_fwd_up);
    cover property (disp_io_fwd);
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the bridge control bank
`timescale 1ns/100ps
`include "bridge_ctrl_consts.vh"
module testbench;
    logic        clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sl, e;
    logic        pin_load_valid = 1'b0, io_req = 1'b0, mem_req = 1'b0, pready, pslverr, irq, hot_reset;
    logic        poison_seen, sec_err_msg, poison_report, err_fwd, io_fwd_down, io_fwd_up, disp_io_fwd, disp_mem_fwd;
    logic [1:0]  kick = 2'h0, port_rst_n;
    logic [7:0]  pin_load_value = 8'h00;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, io_addr = 32'h0, mem_addr = 32'h0, prdata, rd;
    int          err_total = 0, compares = 0;
    bridge_control_config_bank #(.NUM_DOWN(2)) DUT (.*);
    sec_side_model partner (.*);
    initial forever #4 clock = ~clock;
    // Compare and count
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clock);
        penable <= 1'b1;
        // Look at ready mid-cycle, where it is settled for the coming edge
        @(negedge clock);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(negedge clock);
        end
        if (n >= 50) err_total++;
        {sl, rd} = {pslverr, prdata};
        // Edge at which ready is sampled high, then release
        @(posedge clock);
        {psel, penable} <= 2'b00;
    endtask
    // Let registered outputs settle
    task automatic tick;
        repeat (2) @(posedge clock);
        #1;
    endtask
    // Present one I/O and one memory request
    task automatic cls(input logic [31:0] ia, input logic [31:0] ma);
        @(posedge clock);
        {io_req, mem_req, io_addr, mem_addr} <= {2'b11, ia, ma};
        tick;
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        give_verdict;
    end
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        apb(0, `OFS_INT_BRIDGE, 32'h0);
        chk(rd, 32'h0000_0100);
        @(posedge clock);
        {pin_load_valid, pin_load_value} <= 9'h15a;
        @(posedge clock);
        pin_load_valid <= 1'b0;
        apb(1, `OFS_IO_WINDOW, 32'h0);
        apb(1, 12'h200, 32'hffff_ffff);
        chk({sl, rd}, {1'b1, 32'h0});
        // Enables all set, then all clear
        for (int i = 1; i >= 0; i--) begin
            e = i[0];
            apb(1, `OFS_INT_BRIDGE, e ? 32'hffff_ffff : 32'h0);
            apb(1, `OFS_IRQ_MASK, 32'h0);
            apb(0, `OFS_INT_BRIDGE, 32'h0);
            chk(rd, e ? 32'h005f_5aff : 32'h0000_5a00);
            @(posedge clock);
            kick <= 2'h3;
            @(posedge clock);
            kick <= 2'h0;
            // Report pulses stand for one cycle only
            @(posedge clock);
            #1;
            chk({poison_report, err_fwd, irq}, {e, e, 1'b0});
            chk({hot_reset, port_rst_n}, {e, 1'b1, !e});
            apb(1, `OFS_IRQ_MASK, 32'h7);
            tick;
            chk(irq, e);
            apb(0, `OFS_IRQ_STATUS, 32'h0);
            chk(rd, e ? 32'h7 : 32'h0);
            apb(1, `OFS_IRQ_STATUS, 32'h7);
            tick;
            chk(irq, 1'b0);
            cls(32'h0000_0200, 32'h000a_1000);
            chk({io_fwd_down, io_fwd_up, disp_io_fwd, disp_mem_fwd}, {!e, e, 1'b0, e});
            cls(32'h0000_03c4, 32'h000c_0000);
            chk({disp_io_fwd, disp_mem_fwd}, {e, 1'b0});
            $display("enable pass %0d done", i);
        end
        apb(1, `OFS_INT_BRIDGE, 32'h0008_0000);
        cls(32'h0000_13c4, 32'h000b_ffff);
        chk({disp_io_fwd, disp_mem_fwd}, 2'b11);
        cls(32'h0001_03c4, 32'h0);
        chk({io_fwd_down, io_fwd_up, disp_io_fwd}, 3'b000);
        $display("decode test done");
        give_verdict;
    end
endmodule
bind bridge_control_config_bank bridge_bank_checker chk_i (.*);
